// [verilog/rail_fault_pkg.sv]
// Constants, pin indices and state encoding for the rail fault supervisor
package rail_fault_pkg;

   // Timebase: 40 MHz, 25 ns period
   localparam int unsigned CLK_MHZ        = 40;

   // Intervals in microseconds, as specified
   localparam int unsigned AUX_BLANK_US   = 64000;
   localparam int unsigned AUX_DEB_US     = 500;
   localparam int unsigned OC_DEB_US      = 450;
   localparam int unsigned RESTART_US     = 1000000;
   localparam int unsigned PGOOD_DELAY_US = 250000;

   // Derived cycle counts; the undervoltage must last strictly longer, hence one extra cycle
   localparam int unsigned AUX_BLANK_CYC  = AUX_BLANK_US * CLK_MHZ;
   localparam int unsigned AUX_DEB_CYC    = AUX_DEB_US * CLK_MHZ + 1;
   localparam int unsigned OC_DEB_CYC     = OC_DEB_US * CLK_MHZ;
   localparam int unsigned RESTART_CYC    = RESTART_US * CLK_MHZ;
   localparam int unsigned PGOOD_CYC      = PGOOD_DELAY_US * CLK_MHZ;

   // Width of every interval counter (holds 40,000,000)
   localparam int unsigned CNT_W          = 26;

   // Bit positions of the synchronised pin vector
   localparam int unsigned IN_AUX_UV      = 0;
   localparam int unsigned IN_OC12        = 1;
   localparam int unsigned IN_OC5         = 2;
   localparam int unsigned IN_OC33        = 3;
   localparam int unsigned IN_MAINS       = 4;
   localparam int unsigned IN_MAIN_UV     = 5;
   localparam int unsigned IN_REQ         = 6;
   localparam int unsigned IN_SUPPLY_UNDERVOLTAGE_LOCKOUT        = 7;
   localparam int unsigned IN_BOUNCE      = 8;
   localparam int unsigned IN_AUX33       = 9;
   localparam int unsigned IN_OCSEL       = 10;
   localparam int unsigned IN_NUM         = 11;

   // Supervisor states, Gray coded along off -> run -> fault
   typedef enum logic [1:0] {
      S_OFF   = 2'h0,
      S_RUN   = 2'h1,
      S_FAULT = 2'h3
   } sup_state_e;

endpackage : rail_fault_pkg

// [verilog/persist_if.sv]
// Carrier between the supervisor and a persistence filter
interface persist_if;
   logic level;
   logic clear;
   logic hit;

   modport filter (input level, input clear, output hit);
   modport user   (output level, output clear, input hit);
endinterface : persist_if

// [verilog/persist_filter.sv]
// Persistence filter: reports a level only after it has held for LIMIT cycles
module persist_filter
   import rail_fault_pkg::*;
#(
   parameter int unsigned LIMIT = 16
) (
   input  wire logic clk,
   input  wire logic rst_n,
   persist_if.filter p
);
   localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_hit;

   // Any drop of the level restarts the count, so short excursions never qualify
   always_comb begin
      if (p.clear || !p.level) begin
         next_cnt = '0;
      end else if (cnt == LIM) begin
         next_cnt = cnt;
      end else begin
         next_cnt = cnt + CNT_W'(1);
      end
      next_hit = (next_cnt == LIM);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt   <= '0;
         p.hit <= 1'b0;
      end else begin
         cnt   <= next_cnt;
         p.hit <= next_hit;
      end
   end

   a_hit_persist: assert property (@(posedge clk) disable iff (!rst_n)
      p.hit |-> (cnt == LIM) && $past(p.level) && !$past(p.clear))
      else $error("filter hit without full persistence");

endmodule : persist_filter

// [verilog/rail_fault_supervisor.sv]
// Top of the rail fault supervisor: fault latching, restart and power-good sequencing
module rail_fault_supervisor
   import rail_fault_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES   = AUX_BLANK_CYC,
   parameter int unsigned AUX_DEB_CYCLES = AUX_DEB_CYC,
   parameter int unsigned OC_DEB_CYCLES  = OC_DEB_CYC,
   parameter int unsigned RESTART_CYCLES = RESTART_CYC,
   parameter int unsigned PGOOD_CYCLES   = PGOOD_CYC
) (
   // Clock and reset
   input  wire logic CLOCK,
   input  wire logic ARST_N,
   // Supply and request
   input  wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
   input  wire logic POWER_ON_REQUEST,
   // Comparator results
   input  wire logic AUX_UV_CMP,
   input  wire logic MAIN_UV_CMP,
   input  wire logic OC12_CMP,
   input  wire logic OC5_CMP,
   input  wire logic OC33_CMP,
   input  wire logic MAINS_SENSE_INPUT,
   // Programmed options
   input  wire logic BOUNCE_MODE,
   input  wire logic AUX_RAIL_3V3,
   input  wire logic OC_ON_3V3,
   // Fault and sequencing outputs
   output logic      MAIN_FAULT,
   output logic      MAIN_ENABLE,
   output logic      POWER_GOOD_OUT,
   output logic      OVERCURRENT_BOUNCE_EVENT,
   output logic      MAINS_OK_FLAG,
   // Analog configuration outputs
   output logic      AUX_THRESH_3V3,
   output logic      OC5_MON_EN,
   output logic      OC33_MON_EN
);
   localparam logic [CNT_W-1:0] BLANK_N   = CNT_W'(BLANK_CYCLES);
   localparam logic [CNT_W-1:0] RESTART_N = CNT_W'(RESTART_CYCLES);
   localparam logic [CNT_W-1:0] PGOOD_N   = CNT_W'(PGOOD_CYCLES);

   logic              rst_meta;
   logic              rst_n;
   logic [IN_NUM-1:0] pin_in;
   logic [IN_NUM-1:0] pin_meta;
   logic [IN_NUM-1:0] s;

   persist_if aux_p ();
   persist_if oc_p ();

   sup_state_e        state;
   sup_state_e        next_state;
   logic [CNT_W-1:0]  blank_cnt;
   logic [CNT_W-1:0]  next_blank_cnt;
   logic [CNT_W-1:0]  restart_cnt;
   logic [CNT_W-1:0]  next_restart_cnt;
   logic [CNT_W-1:0]  pg_cnt;
   logic [CNT_W-1:0]  next_pg_cnt;
   logic              aux_latch;
   logic              next_aux_latch;
   logic              oc_latch;
   logic              next_oc_latch;
   logic              req_q;
   logic              supply_undervoltage_lockout;
   logic              req_fall;
   logic              aux_armed;
   logic              restart_done;
   logic              pg_cond;
   logic              next_main_fault;
   logic              next_main_enable;
   logic              next_power_good;
   logic              next_bounce_event;
   logic              next_oc5_mon;

   // Reset release through two flops
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign pin_in = {OC_ON_3V3, AUX_RAIL_3V3, BOUNCE_MODE, SUPPLY_UNDERVOLTAGE_LOCKOUT,
                    POWER_ON_REQUEST, MAIN_UV_CMP, MAINS_SENSE_INPUT, OC33_CMP, OC5_CMP,
                    OC12_CMP, AUX_UV_CMP};

   // Every pin is asynchronous to CLOCK
   for (genvar i = 0; i < IN_NUM; i++) begin : g_sync
      always_ff @(posedge CLOCK or negedge rst_n) begin
         if (!rst_n) begin
            pin_meta[i] <= 1'b0;
            s[i]        <= 1'b0;
         end else begin
            pin_meta[i] <= pin_in[i];
            s[i]        <= pin_meta[i];
         end
      end
   end

   assign supply_undervoltage_lockout         = s[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT];
   assign req_fall     = req_q && !s[IN_REQ];
   assign aux_armed    = (blank_cnt == BLANK_N);
   assign restart_done = (state == S_FAULT) && s[IN_BOUNCE] && (restart_cnt == RESTART_N);

   assign aux_p.clear  = supply_undervoltage_lockout;
   assign aux_p.level  = s[IN_AUX_UV] && aux_armed;
   assign oc_p.clear   = supply_undervoltage_lockout;
   assign oc_p.level   = s[IN_OC12] || (s[IN_OCSEL] ? s[IN_OC33] : s[IN_OC5]);

   persist_filter #(.LIMIT(AUX_DEB_CYCLES)) u_aux_deb (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .p     (aux_p)
   );

   persist_filter #(.LIMIT(OC_DEB_CYCLES)) u_oc_deb (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .p     (oc_p)
   );

   always_comb begin
      // Blanking timer restarts whenever lockout is present
      if (supply_undervoltage_lockout) begin
         next_blank_cnt = '0;
      end else if (aux_armed) begin
         next_blank_cnt = blank_cnt;
      end else begin
         next_blank_cnt = blank_cnt + CNT_W'(1);
      end

      // A new fault in the release cycle is kept: set wins over clear
      next_aux_latch = !supply_undervoltage_lockout && (aux_p.hit ||
                       (aux_latch && !req_fall && !restart_done));
      next_oc_latch  = !supply_undervoltage_lockout && (oc_p.hit ||
                       (oc_latch && !req_fall && !restart_done));

      next_state = state;
      case (state)
         S_OFF: begin
            if (!supply_undervoltage_lockout && s[IN_REQ] && !aux_latch && !oc_latch) begin
               next_state = S_RUN;
            end
         end
         S_RUN: begin
            if (aux_p.hit || oc_p.hit || aux_latch || oc_latch) begin
               next_state = S_FAULT;
            end else if (!s[IN_REQ]) begin
               next_state = S_OFF;
            end
         end
         S_FAULT: begin
            if (req_fall || restart_done) begin
               next_state = S_OFF;
            end
         end
         default: begin
            next_state = S_OFF;
         end
      endcase
      if (supply_undervoltage_lockout) begin
         next_state = S_OFF;
      end

      // Restart wait only runs in bounce mode; latching mode never times out
      if ((state == S_FAULT) && s[IN_BOUNCE] && !restart_done) begin
         next_restart_cnt = restart_cnt + CNT_W'(1);
      end else begin
         next_restart_cnt = '0;
      end

      pg_cond = s[IN_MAINS] && !s[IN_MAIN_UV] && (state == S_RUN) &&
                !aux_p.hit && !oc_p.hit && !aux_latch && !oc_latch;
      if (!pg_cond) begin
         next_pg_cnt = '0;
      end else if (pg_cnt == PGOOD_N) begin
         next_pg_cnt = pg_cnt;
      end else begin
         next_pg_cnt = pg_cnt + CNT_W'(1);
      end

      next_main_fault   = next_aux_latch || next_oc_latch;
      next_main_enable  = (next_state == S_RUN) && !aux_p.hit;
      next_power_good   = pg_cond && (pg_cnt == PGOOD_N);
      next_bounce_event = aux_p.hit && !supply_undervoltage_lockout;
      next_oc5_mon      = !s[IN_OCSEL];
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state                    <= S_OFF;
         blank_cnt                <= '0;
         restart_cnt              <= '0;
         pg_cnt                   <= '0;
         aux_latch                <= 1'b0;
         oc_latch                 <= 1'b0;
         req_q                    <= 1'b0;
         MAIN_FAULT               <= 1'b0;
         MAIN_ENABLE              <= 1'b0;
         POWER_GOOD_OUT           <= 1'b0;
         OVERCURRENT_BOUNCE_EVENT <= 1'b0;
         MAINS_OK_FLAG            <= 1'b0;
         AUX_THRESH_3V3           <= 1'b0;
         OC5_MON_EN               <= 1'b0;
         OC33_MON_EN              <= 1'b0;
      end else begin
         state                    <= next_state;
         blank_cnt                <= next_blank_cnt;
         restart_cnt              <= next_restart_cnt;
         pg_cnt                   <= next_pg_cnt;
         aux_latch                <= next_aux_latch;
         oc_latch                 <= next_oc_latch;
         req_q                    <= s[IN_REQ];
         MAIN_FAULT               <= next_main_fault;
         MAIN_ENABLE              <= next_main_enable;
         POWER_GOOD_OUT           <= next_power_good;
         OVERCURRENT_BOUNCE_EVENT <= next_bounce_event;
         MAINS_OK_FLAG            <= s[IN_MAINS];
         AUX_THRESH_3V3           <= s[IN_AUX33];
         OC5_MON_EN               <= next_oc5_mon;
         OC33_MON_EN              <= s[IN_OCSEL];
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   a_blank_gate: assert property (!aux_armed |-> !aux_p.hit && !OVERCURRENT_BOUNCE_EVENT)
      else $error("aux undervoltage acted during blanking");
   a_aux_fault_set: assert property (aux_p.hit && !supply_undervoltage_lockout |=> MAIN_FAULT && !MAIN_ENABLE)
      else $error("aux undervoltage did not raise fault");
   a_fault_no_pgood: assert property (MAIN_FAULT |-> !POWER_GOOD_OUT)
      else $error("power-good high with main fault");
   a_mains_drop: assert property (!s[IN_MAINS] |=> !POWER_GOOD_OUT)
      else $error("power-good high with mains low");
   a_oc_latched: assert property (oc_latch && !s[IN_BOUNCE] && !supply_undervoltage_lockout && !req_fall
      |=> oc_latch && MAIN_FAULT)
      else $error("latching mode overcurrent released");
   a_restart_release: assert property (restart_done && !aux_p.hit && !oc_p.hit
      |=> !MAIN_FAULT && state == S_OFF)
      else $error("bounce restart did not release fault");
   a_uv_held: assert property (aux_latch && !req_fall && !restart_done && !supply_undervoltage_lockout
      |=> aux_latch)
      else $error("undervoltage latch cleared early");
   a_pg_delay: assert property ($rose(POWER_GOOD_OUT) |-> $past(pg_cnt) == PGOOD_N)
      else $error("power-good rose before delay");
   a_supply_undervoltage_lockout_clear: assert property (supply_undervoltage_lockout |=> !MAIN_FAULT && blank_cnt == '0)
      else $error("lockout did not clear fault state");
   // Both selects sit at zero in the first cycle after reset release
   a_mon_select: assert property ($past(rst_n) |-> OC5_MON_EN != OC33_MON_EN)
      else $error("overcurrent monitor selection invalid");

   c_aux_fault: cover property (aux_p.hit ##1 MAIN_FAULT);
   c_oc_restart: cover property (restart_done ##1 state == S_OFF);
   c_pgood_up: cover property ($rose(POWER_GOOD_OUT));
   c_req_cycle: cover property (state == S_FAULT && req_fall);

endmodule : rail_fault_supervisor

// [dv/rail_partner.sv]
// Behavioural main converter: rails settle a few cycles after enable
module rail_partner #(
   parameter int unsigned RISE = 6
) (
   // Clock
   input  wire logic clock,
   // Converter control and rail status
   input  wire logic enable,
   output logic      main_uv
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned ramp;
   initial begin
      ramp = 0;
      main_uv = 1'b1;
   end
   // Rails collapse at once when disabled, as a real converter would
   always @(posedge clock) begin
      if (!enable) begin
         ramp <= 0;
         main_uv <= 1'b1;
      end else if (ramp < RISE) begin
         ramp <= ramp + 1;
      end else begin
         main_uv <= 1'b0;
      end
   end
endmodule : rail_partner

// [dv/rail_fault_supervisor_test.sv]
// Self-checking bench for the rail fault supervisor
module rail_fault_supervisor_test;
   import rail_fault_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned BL = 20, AD = 9, OD = 8, RS = 30, PG = 25;
   logic clock = 0, arst_n = 0, lockout = 0, req = 0, aux_uv = 0, main_uv;
   logic oc12 = 0, oc5 = 0, oc33 = 0, mains = 1, bounce = 0, aux33 = 0, oc_3v3 = 0;
   logic [7:0] outs;
   int miscompares = 0, checked = 0;
   rail_fault_supervisor #(.BLANK_CYCLES(BL), .AUX_DEB_CYCLES(AD), .OC_DEB_CYCLES(OD),
      .RESTART_CYCLES(RS), .PGOOD_CYCLES(PG)) uut (
      .CLOCK(clock), .ARST_N(arst_n), .SUPPLY_UNDERVOLTAGE_LOCKOUT(lockout),
      .POWER_ON_REQUEST(req), .AUX_UV_CMP(aux_uv), .MAIN_UV_CMP(main_uv), .OC12_CMP(oc12),
      .OC5_CMP(oc5), .OC33_CMP(oc33), .MAINS_SENSE_INPUT(mains), .BOUNCE_MODE(bounce),
      .AUX_RAIL_3V3(aux33), .OC_ON_3V3(oc_3v3), .MAIN_FAULT(outs[0]), .MAIN_ENABLE(outs[1]),
      .POWER_GOOD_OUT(outs[2]), .OVERCURRENT_BOUNCE_EVENT(outs[3]), .MAINS_OK_FLAG(outs[4]),
      .AUX_THRESH_3V3(outs[5]), .OC5_MON_EN(outs[6]), .OC33_MON_EN(outs[7]));
   rail_partner partner (.clock(clock), .enable(outs[1]), .main_uv(main_uv));
   initial begin
      forever #12.5 clock = ~clock;
   end
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // Inputs: 0 aux, 1 oc12, 2 oc5, 3 oc33, 4 mains, 5 request, 6 lockout, 7 bounce
   task automatic drive(input int sel, input logic v);
      @(posedge clock);
      case (sel)
         0: aux_uv <= v;
         1: oc12 <= v;
         2: oc5 <= v;
         3: oc33 <= v;
         4: mains <= v;
         5: req <= v;
         6: lockout <= v;
         default: bounce <= v;
      endcase
   endtask : drive
   task automatic hold_high(input int sel, input int n);
      drive(sel, 1'b1);
      cyc(n);
      drive(sel, 1'b0);
   endtask : hold_high
   task automatic chk(input int sel, input logic exp, input string msg);
      checked++;
      if (outs[sel] !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_for(input int sel, input logic val, input int bound);
      for (int i = 0; i < bound; i++) begin
         cyc(1);
         if (outs[sel] === val) return;
      end
      miscompares++;
      $display("mismatch at %0t: output %0d timed out", $time, sel);
      give_verdict();
   endtask : wait_for
   task automatic t_power_up();
      @(posedge clock);
      aux33 <= 1'b1;
      oc_3v3 <= 1'b1;
      cyc(5);
      chk(5, 1'b1, "aux threshold option");
      chk(7, 1'b1, "3.3V monitor enable");
      chk(6, 1'b0, "5V monitor enable");
      drive(5, 1'b1);
      wait_for(1, 1'b1, 10);
      cyc(20);
      chk(2, 1'b0, "power good early");
      wait_for(2, 1'b1, 60);
      $display("test power_up done");
   endtask : t_power_up
   task automatic t_mains();
      drive(4, 1'b0);
      wait_for(2, 1'b0, 6);
      chk(4, 1'b0, "mains flag");
      drive(4, 1'b1);
      cyc(PG - 5);
      chk(2, 1'b0, "power good delay after mains");
      wait_for(2, 1'b1, 40);
      chk(4, 1'b1, "mains flag restored");
      $display("test mains done");
   endtask : t_mains
   task automatic t_aux();
      hold_high(6, 4);
      hold_high(0, 14);
      cyc(6);
      chk(0, 1'b0, "aux fault during blanking");
      cyc(30);
      hold_high(0, AD - 2);
      cyc(6);
      chk(0, 1'b0, "short aux dip");
      chk(3, 1'b0, "short aux dip bounce event");
      drive(0, 1'b1);
      cyc(AD + 2);
      chk(0, 1'b0, "aux fault too early");
      wait_for(0, 1'b1, 2);
      cyc(1);
      chk(3, 1'b1, "bounce event");
      chk(1, 1'b0, "enable dropped");
      chk(2, 1'b0, "power good dropped");
      drive(0, 1'b0);
      wait_for(3, 1'b0, 6);
      cyc(RS + 10);
      chk(0, 1'b1, "latched aux fault");
      drive(5, 1'b0);
      wait_for(0, 1'b0, 6);
      drive(5, 1'b1);
      wait_for(1, 1'b1, 10);
      $display("test aux done");
   endtask : t_aux
   task automatic t_oc();
      for (int s = 1; s <= 3; s++) begin
         hold_high(s, OD - 2);
         cyc(6);
         chk(0, 1'b0, "short overcurrent");
      end
      drive(3, 1'b0);
      @(posedge clock);
      oc_3v3 <= 1'b0;
      hold_high(3, 20);
      cyc(6);
      chk(0, 1'b0, "unselected 3.3V monitor");
      drive(1, 1'b1);
      cyc(OD + 2);
      chk(0, 1'b0, "overcurrent fault too early");
      wait_for(0, 1'b1, 2);
      drive(1, 1'b0);
      cyc(RS + 30);
      chk(0, 1'b1, "latching overcurrent");
      drive(5, 1'b0);
      wait_for(0, 1'b0, 6);
      drive(7, 1'b1);
      drive(5, 1'b1);
      wait_for(1, 1'b1, 10);
      hold_high(2, OD + 4);
      wait_for(0, 1'b1, 10);
      cyc(RS - 15);
      chk(0, 1'b1, "restart too early");
      wait_for(0, 1'b0, RS + 10);
      wait_for(1, 1'b1, 10);
      $display("test overcurrent done");
   endtask : t_oc
   task automatic t_lockout();
      hold_high(1, 20);
      wait_for(0, 1'b1, 10);
      drive(6, 1'b1);
      wait_for(0, 1'b0, 6);
      drive(6, 1'b0);
      $display("test lockout done");
   endtask : t_lockout
   initial begin
      cyc(7);
      @(posedge clock);
      arst_n <= 1'b1;
      cyc(6);
      chk(0, 1'b0, "fault after reset");
      chk(5, 1'b0, "aux threshold option after reset");
      chk(6, 1'b1, "5V monitor enable after reset");
      t_power_up();
      t_mains();
      t_aux();
      t_oc();
      t_lockout();
      give_verdict();
   end
endmodule : rail_fault_supervisor_test
